//--- pwr_wake_pkg.sv
// Constants, register map and state encoding for the power and wake-up sequencer
`default_nettype none

package pwr_wake_pkg;

   //---------------------------------------------------------------------
   // Clock and timing
   //---------------------------------------------------------------------
   localparam int CLK_HZ        = 25_000_000;
   localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
   localparam int BOOT_TIME_MS  = 3000;      // Initialization on-time after first supply
   localparam int BEEP_SHORT_MS = 100;       // Length of one short tone
   localparam int SLOT_MS       = 250;       // One slot of flash code and tone sequence
   localparam int ETH_IDLE_MS   = 1000;      // Ethernet inactivity interval after reset
   localparam int PIN_FILT_US   = 10;        // Wake pin glitch filter after reset
   localparam int TRIG_MIN_US   = 1000;      // Trigger minimum pulse width after reset
   localparam int BOOT_CYCLES   = BOOT_TIME_MS * 1000 * CYC_PER_US;
   localparam int BEEP_CYCLES   = BEEP_SHORT_MS * 1000 * CYC_PER_US;
   localparam int SLOT_CYCLES   = SLOT_MS * 1000 * CYC_PER_US;
   localparam int ETH_IDLE_CYC  = ETH_IDLE_MS * 1000 * CYC_PER_US;
   localparam int PIN_FILT_CYC  = PIN_FILT_US * CYC_PER_US;
   localparam int TRIG_MIN_CYC  = TRIG_MIN_US * CYC_PER_US;

   //---------------------------------------------------------------------
   // Register map (byte addresses)
   //---------------------------------------------------------------------
   localparam logic [7:0] OFS_WAKE_CFG = 8'h00;
   localparam logic [7:0] OFS_ETH_IDLE = 8'h04;
   localparam logic [7:0] OFS_PIN_FILT = 8'h08;
   localparam logic [7:0] OFS_TRIG_MIN = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_TRIG_EVT = 8'h14;

   // Wake configuration fields
   localparam int WCFG_W             = 7;
   localparam int WCFG_ECU           = 0;
   localparam int WCFG_BUS1          = 1;
   localparam int WCFG_BUS2          = 2;
   localparam int WCFG_PIN           = 3;
   localparam int WCFG_EXT           = 4;
   localparam int WCFG_BUS1_HS       = 5;
   localparam int WCFG_BUS2_HS       = 6;
   localparam logic [6:0] WCFG_RESET = 7'h7F;

   // Trigger event flags
   localparam int EVT_PRESS  = 0;
   localparam int EVT_CHANGE = 1;

   //---------------------------------------------------------------------
   // Synchronizer bit positions
   //---------------------------------------------------------------------
   localparam int SY_SUPPLY  = 0;
   localparam int SY_SEL_ON  = 1;
   localparam int SY_PIN     = 2;
   localparam int SY_TRIG_A  = 3;
   localparam int SY_TRIG_B  = 4;
   localparam int SY_ETH     = 5;
   localparam int SY_ECU     = 6;
   localparam int SY_BUS1    = 7;
   localparam int SY_BUS2    = 8;
   localparam int SY_EXT     = 9;
   localparam int SY_PATTERN = 10;
   localparam int SY_CRIT    = 11;
   localparam int SY_OVER    = 12;
   localparam int SYNC_W     = 13;

   // Supply states
   typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_ON} supply_state_e;

endpackage

`default_nettype wire

//--- power_wakeup_sequencer.sv
// Supply state, wake-up, trigger and beeper controller with APB registers
//
// Overview of operation
// - Exactly one of Off, Standby, On is held at any time.
// - Selector on: On while supply present and no over-temperature, Off once supply goes away.
// - Selector auto: Standby held until a wake event or selector on.
// - Standby: interfaces not stimulated, indicator flashes green code three.
// - On: rails and interfaces enabled, wake logic on, indicator steady green.
// - Off: all interfaces disabled and wake logic inactive.
// - Wake logic moves between Standby and On only in auto position.
// - Wake on Ethernet, high-speed bus, extension traffic or high wake pin.
// - Extension-reported FlexRay wake pattern is also a wake event.
// - Back to Standby when all enabled traffic stops and pin is low.
// - Each source has an enable; Ethernet and selector always active.
// - Wake pin high means wake, low means sleep.
// - Short glitches on the wake pin are filtered out.
// - Any change between trigger inputs is an event; press raises interrupt.
// - Present trigger button state is readable for polling.
// - Trigger accepted only after a configurable minimum pulse width.
// - Ethernet link signalling moves Standby to On at once.
// - Ethernet loss returns to Standby only after an idle interval.
// - First supply: on for an initialization period, then one short beep.
// - Short tone at boot; repeated short tones at critical temperature.
// - Continuous tone while temperature is beyond critical.
// - Over-temperature stops the model and forces Standby.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module power_wakeup_sequencer
   import pwr_wake_pkg::*;
#(
   parameter int BOOT_CYC   = BOOT_CYCLES,
   parameter int BEEP_CYC   = BEEP_CYCLES,
   parameter int SLOT_CYC   = SLOT_CYCLES,
   parameter int ETH_IDLE_D = ETH_IDLE_CYC,
   parameter int PIN_FILT_D = PIN_FILT_CYC,
   parameter int TRIG_MIN_D = TRIG_MIN_CYC
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SUPPLY_PRESENT,
   input  wire logic        SELECT_ON,
   input  wire logic        WAKE_PIN,
   input  wire logic        TRIG_A,
   input  wire logic        TRIG_B,
   input  wire logic        ETH_LINK,
   input  wire logic        ECU_TRAFFIC,
   input  wire logic        BUS1_TRAFFIC,
   input  wire logic        BUS2_TRAFFIC,
   input  wire logic        EXT_TRAFFIC,
   input  wire logic        EXT_WAKE_PATTERN,
   input  wire logic        TEMP_CRIT,
   input  wire logic        TEMP_OVER,
   output logic             RAILS_EN,
   output logic             IF_EN,
   output logic             WAKE_LOGIC_EN,
   output logic             MODEL_RUN,
   output logic             LED_GREEN,
   output logic             BEEP,
   output logic             TRIG_IRQ,
   output logic [1:0]       STATE
);

   //---------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------
   // Down-counter step that stops at zero
   function automatic logic [31:0] dec_sat(input logic [31:0] v);
      dec_sat = (v == 32'h0) ? 32'h0 : 32'(v - 32'h1);
   endfunction

   //---------------------------------------------------------------------
   // Input synchronizers
   //---------------------------------------------------------------------
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;

   assign async_in = {TEMP_OVER, TEMP_CRIT, EXT_WAKE_PATTERN, EXT_TRAFFIC, BUS2_TRAFFIC,
                      BUS1_TRAFFIC, ECU_TRAFFIC, ETH_LINK, TRIG_B, TRIG_A, WAKE_PIN,
                      SELECT_ON, SUPPLY_PRESENT};

   // Two stages; only the second stage is read by logic
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (CE) begin
         sync_a <= async_in;
         sync_b <= sync_a;
      end
   end

   logic supply_s;
   logic sel_on_s;
   logic crit_s;
   logic over_s;
   assign supply_s = sync_b[SY_SUPPLY];
   assign sel_on_s = sync_b[SY_SEL_ON];
   assign crit_s   = sync_b[SY_CRIT];
   assign over_s   = sync_b[SY_OVER];

   //---------------------------------------------------------------------
   // Register bus
   //---------------------------------------------------------------------
   logic [WCFG_W-1:0] wake_cfg;
   logic [31:0]       eth_idle;
   logic [31:0]       pin_filt;
   logic [31:0]       trig_min;
   logic [1:0]        trig_evt;
   logic [WCFG_W-1:0] next_wake_cfg;
   logic [31:0]       next_eth_idle;
   logic [31:0]       next_pin_filt;
   logic [31:0]       next_trig_min;
   logic [1:0]        next_trig_evt;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic [1:0]        evt_set;
   logic [31:0]       status_word;
   logic              bus_wr;

   assign bus_wr = PSEL && PENABLE && PREADY && PWRITE;

   // Decode, read mux and write strobes; answer one cycle into the access phase
   always_comb begin
      next_wake_cfg = wake_cfg;
      next_eth_idle = eth_idle;
      next_pin_filt = pin_filt;
      next_trig_min = trig_min;
      next_pready   = PSEL && PENABLE && !PREADY;
      next_prdata   = 32'h0;
      next_pslverr  = 1'b0;
      if (bus_wr) begin
         case (PADDR)
            OFS_WAKE_CFG: next_wake_cfg = PWDATA[WCFG_W-1:0];
            OFS_ETH_IDLE: next_eth_idle = PWDATA;
            OFS_PIN_FILT: next_pin_filt = PWDATA;
            OFS_TRIG_MIN: next_trig_min = PWDATA;
            default: ;
         endcase
      end
      if (next_pready) begin
         case (PADDR)
            OFS_WAKE_CFG: next_prdata = {25'h0, wake_cfg};
            OFS_ETH_IDLE: next_prdata = eth_idle;
            OFS_PIN_FILT: next_prdata = pin_filt;
            OFS_TRIG_MIN: next_prdata = trig_min;
            OFS_STATUS:   next_prdata = status_word;
            OFS_TRIG_EVT: next_prdata = {30'h0, trig_evt};
            default:      next_pslverr = 1'b1;
         endcase
      end
      // Write one to clear; a new event in the same cycle wins
      next_trig_evt = trig_evt;
      if (bus_wr && PADDR == OFS_TRIG_EVT) begin
         next_trig_evt = trig_evt & ~PWDATA[1:0];
      end
      next_trig_evt = next_trig_evt | evt_set;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wake_cfg <= WCFG_RESET;
         eth_idle <= 32'(ETH_IDLE_D);
         pin_filt <= 32'(PIN_FILT_D);
         trig_min <= 32'(TRIG_MIN_D);
         trig_evt <= 2'h0;
         PRDATA   <= 32'h0;
         PREADY   <= 1'b0;
         PSLVERR  <= 1'b0;
         TRIG_IRQ <= 1'b0;
      end else if (CE) begin
         wake_cfg <= next_wake_cfg;
         eth_idle <= next_eth_idle;
         pin_filt <= next_pin_filt;
         trig_min <= next_trig_min;
         trig_evt <= next_trig_evt;
         PRDATA   <= next_prdata;
         PREADY   <= next_pready;
         PSLVERR  <= next_pslverr;
         TRIG_IRQ <= next_trig_evt[EVT_PRESS];
      end
   end

   //---------------------------------------------------------------------
   // Input filters and Ethernet activity
   //---------------------------------------------------------------------
   logic        pin_f;
   logic [31:0] pin_cnt;
   logic        trig_f;
   logic [31:0] trig_cnt;
   logic [31:0] eth_cnt;
   logic        next_pin_f;
   logic [31:0] next_pin_cnt;
   logic        next_trig_f;
   logic [31:0] next_trig_cnt;
   logic [31:0] next_eth_cnt;
   logic        trig_raw;
   logic        eth_act;

   assign trig_raw = sync_b[SY_TRIG_A] ^ sync_b[SY_TRIG_B];
   assign eth_act  = sync_b[SY_ETH] || (eth_cnt != 32'h0);

   // A level must hold for the programmed count before it is taken
   always_comb begin
      next_pin_f    = pin_f;
      next_pin_cnt  = 32'h0;
      next_trig_f   = trig_f;
      next_trig_cnt = 32'h0;
      evt_set       = 2'h0;
      if (sync_b[SY_PIN] != pin_f) begin
         next_pin_cnt = 32'(pin_cnt + 32'h1);
         if (next_pin_cnt >= pin_filt) begin
            next_pin_f   = sync_b[SY_PIN];
            next_pin_cnt = 32'h0;
         end
      end
      if (trig_raw != trig_f) begin
         next_trig_cnt = 32'(trig_cnt + 32'h1);
         if (next_trig_cnt >= trig_min) begin
            next_trig_f   = trig_raw;
            next_trig_cnt = 32'h0;
            evt_set[EVT_CHANGE] = 1'b1;
            evt_set[EVT_PRESS]  = trig_raw;
         end
      end
      // Idle interval restarts on every link signal
      next_eth_cnt = sync_b[SY_ETH] ? eth_idle : dec_sat(eth_cnt);
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_f    <= 1'b0;
         pin_cnt  <= 32'h0;
         trig_f   <= 1'b0;
         trig_cnt <= 32'h0;
         eth_cnt  <= 32'h0;
      end else if (CE) begin
         pin_f    <= next_pin_f;
         pin_cnt  <= next_pin_cnt;
         trig_f   <= next_trig_f;
         trig_cnt <= next_trig_cnt;
         eth_cnt  <= next_eth_cnt;
      end
   end

   //---------------------------------------------------------------------
   // Wake sources
   //---------------------------------------------------------------------
   logic wake_hold;
   logic wake_req;

   // Traffic levels that keep the module on; the pattern only starts it
   assign wake_hold = eth_act
      || (wake_cfg[WCFG_ECU] && sync_b[SY_ECU])
      || (wake_cfg[WCFG_BUS1] && wake_cfg[WCFG_BUS1_HS] && sync_b[SY_BUS1])
      || (wake_cfg[WCFG_BUS2] && wake_cfg[WCFG_BUS2_HS] && sync_b[SY_BUS2])
      || (wake_cfg[WCFG_EXT] && sync_b[SY_EXT])
      || (wake_cfg[WCFG_PIN] && pin_f);
   assign wake_req = wake_hold || (wake_cfg[WCFG_EXT] && sync_b[SY_PATTERN]);

   //---------------------------------------------------------------------
   // Supply state machine
   //---------------------------------------------------------------------
   supply_state_e state;
   supply_state_e next_state;
   logic          booted;
   logic [31:0]   boot_cnt;
   logic          boot_done;
   logic          next_booted;
   logic [31:0]   next_boot_cnt;

   // Priority: no supply, over-temperature, boot, selector, wake logic
   always_comb begin
      next_booted   = booted;
      next_boot_cnt = boot_cnt;
      boot_done     = 1'b0;
      next_state    = state;
      if (!supply_s) begin
         next_state    = ST_OFF;
         next_booted   = 1'b0;
         next_boot_cnt = 32'(BOOT_CYC);
      end else begin
         if (!booted) begin
            if (boot_cnt <= 32'h1) begin
               next_booted = 1'b1;
               boot_done   = 1'b1;
            end
            next_boot_cnt = dec_sat(boot_cnt);
         end
         if (over_s) begin
            next_state = ST_STANDBY;
         end else if (!booted || sel_on_s) begin
            next_state = ST_ON;
         end else begin
            case (state)
               ST_ON:      next_state = wake_hold ? ST_ON : ST_STANDBY;
               ST_STANDBY: next_state = wake_req ? ST_ON : ST_STANDBY;
               ST_OFF:     next_state = ST_STANDBY;
               default:    next_state = ST_OFF;
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state         <= ST_OFF;
         booted        <= 1'b0;
         boot_cnt      <= 32'(BOOT_CYC);
         RAILS_EN      <= 1'b0;
         IF_EN         <= 1'b0;
         WAKE_LOGIC_EN <= 1'b0;
         MODEL_RUN     <= 1'b0;
         STATE         <= 2'h0;
      end else if (CE) begin
         state         <= next_state;
         booted        <= next_booted;
         boot_cnt      <= next_boot_cnt;
         RAILS_EN      <= (next_state == ST_ON);
         IF_EN         <= (next_state == ST_ON);
         WAKE_LOGIC_EN <= (next_state != ST_OFF);
         MODEL_RUN     <= (next_state == ST_ON) && !over_s;
         STATE         <= next_state;
      end
   end

   assign status_word = {23'h0, over_s, crit_s, eth_act, pin_f, sel_on_s, trig_f, booted,
                         state};

   //---------------------------------------------------------------------
   // Indicator and beeper
   //---------------------------------------------------------------------
   logic [31:0] slot_cnt;
   logic [2:0]  slot;
   logic [31:0] beep_cnt;
   logic [31:0] next_slot_cnt;
   logic [2:0]  next_slot;
   logic [31:0] next_beep_cnt;
   logic        flash_on;

   // Eight slots: on in slots 0, 2 and 4 gives three flashes and a pause
   assign flash_on = !slot[0] && (slot < 3'h6);

   always_comb begin
      next_slot = slot;
      if (slot_cnt == 32'h0) begin
         next_slot_cnt = 32'(SLOT_CYC - 1);
         next_slot     = slot + 3'h1;
      end else begin
         next_slot_cnt = 32'(slot_cnt - 32'h1);
      end
      next_beep_cnt = boot_done ? 32'(BEEP_CYC) : dec_sat(beep_cnt);
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         slot_cnt  <= 32'h0;
         slot      <= 3'h0;
         beep_cnt  <= 32'h0;
         LED_GREEN <= 1'b0;
         BEEP      <= 1'b0;
      end else if (CE) begin
         slot_cnt  <= next_slot_cnt;
         slot      <= next_slot;
         beep_cnt  <= next_beep_cnt;
         LED_GREEN <= (next_state == ST_ON)
                      || (next_state == ST_STANDBY && flash_on);
         BEEP      <= over_s || (crit_s && flash_on)
                      || (next_beep_cnt != 32'h0);
      end
   end

   //---------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_supply_lost;
      CE && !supply_s;
   endsequence

   sequence s_disabled;
      !RAILS_EN && !IF_EN && !WAKE_LOGIC_EN;
   endsequence

   property p_one_state;
      state inside {ST_OFF, ST_STANDBY, ST_ON};
   endproperty
   a_one_state: assert property (p_one_state) else $error("state out of range");

   property p_on_mode;
      CE && supply_s && sel_on_s && !over_s |=> state == ST_ON && RAILS_EN;
   endproperty
   a_on_mode: assert property (p_on_mode) else $error("selector on not honoured");

   property p_auto_hold;
      CE && state == ST_STANDBY && supply_s && !sel_on_s && booted && !wake_req
         |=> state == ST_STANDBY;
   endproperty
   a_auto_hold: assert property (p_auto_hold) else $error("left standby unwoken");

   property p_standby_quiet;
      state == ST_STANDBY |-> !IF_EN && !RAILS_EN && !MODEL_RUN;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("standby drives");

   property p_on_outputs;
      state == ST_ON |-> RAILS_EN && IF_EN && WAKE_LOGIC_EN && LED_GREEN;
   endproperty
   a_on_outputs: assert property (p_on_outputs) else $error("on outputs wrong");

   property p_off;
      s_supply_lost |=> state == ST_OFF ##0 s_disabled;
   endproperty
   a_off: assert property (p_off) else $error("off not disabled");

   property p_wake;
      CE && state == ST_STANDBY && supply_s && !over_s && wake_req |=> state == ST_ON;
   endproperty
   a_wake: assert property (p_wake) else $error("wake event missed");

   property p_sleep;
      CE && state == ST_ON && supply_s && booted && !sel_on_s && !over_s && !wake_hold
         |=> state == ST_STANDBY;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no return to standby");

   property p_eth_idle;
      CE && sync_b[SY_ETH] ##1 CE && !sync_b[SY_ETH] && eth_idle > 32'h1 |-> eth_act;
   endproperty
   a_eth_idle: assert property (p_eth_idle) else $error("eth idle too short");

   property p_pin_filter;
      CE && pin_f != $past(pin_f) |-> $past(pin_cnt) + 32'h1 >= $past(pin_filt);
   endproperty
   a_pin_filter: assert property (p_pin_filter) else $error("pin glitch passed");

   property p_press_irq;
      CE && evt_set[EVT_PRESS] |=> TRIG_IRQ && trig_evt[EVT_PRESS];
   endproperty
   a_press_irq: assert property (p_press_irq) else $error("press lost");

   property p_over;
      CE && supply_s && over_s |=> BEEP && state == ST_STANDBY && !MODEL_RUN;
   endproperty
   a_over: assert property (p_over) else $error("overtemp not handled");

endmodule

`default_nettype wire

//--- wake_env.sv
// Far-side model: supply, selector, ignition line, wake sources, trigger button, temperature
`timescale 1ns/1ps
`default_nettype none
module wake_env
   import pwr_wake_pkg::*;
(
   input  wire logic CLK,
   output logic      SUPPLY_PRESENT,
   output logic      SELECT_ON,
   output logic      WAKE_PIN,
   output logic      TRIG_A,
   output logic      TRIG_B,
   output logic      ETH_LINK,
   output logic      ECU_TRAFFIC,
   output logic      BUS1_TRAFFIC,
   output logic      BUS2_TRAFFIC,
   output logic      EXT_TRAFFIC,
   output logic      EXT_WAKE_PATTERN,
   output logic      TEMP_CRIT,
   output logic      TEMP_OVER
);
   logic [SYNC_W-1:0] lv = '0;
   // Each line follows its own level bit
   assign SUPPLY_PRESENT   = lv[SY_SUPPLY];
   assign SELECT_ON        = lv[SY_SEL_ON];
   assign WAKE_PIN         = lv[SY_PIN];
   assign TRIG_A           = lv[SY_TRIG_A];
   assign TRIG_B           = lv[SY_TRIG_B];
   assign ETH_LINK         = lv[SY_ETH];
   assign ECU_TRAFFIC      = lv[SY_ECU];
   assign BUS1_TRAFFIC     = lv[SY_BUS1];
   assign BUS2_TRAFFIC     = lv[SY_BUS2];
   assign EXT_TRAFFIC      = lv[SY_EXT];
   assign EXT_WAKE_PATTERN = lv[SY_PATTERN];
   assign TEMP_CRIT        = lv[SY_CRIT];
   assign TEMP_OVER        = lv[SY_OVER];
   // Change one level just after a rising edge
   task automatic set(input int b, input logic v);
      @(posedge CLK);
      lv[b] <= v;
   endtask
   // Short activity burst, also used for host link pulses
   task automatic pulse(input int b, input int n);
      set(b, 1'b1);
      repeat (n) @(posedge CLK);
      lv[b] <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- power_wakeup_sequencer_tb.sv
// Self-checking bench for the power and wake-up sequencer
`timescale 1ns/1ps
`default_nettype none
module power_wakeup_sequencer_tb
   import pwr_wake_pkg::*;
;
   logic CLK, RST_B, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd, v;
   logic [1:0] STATE;
   logic SUPPLY_PRESENT, SELECT_ON, WAKE_PIN, TRIG_A, TRIG_B, ETH_LINK, ECU_TRAFFIC;
   logic BUS1_TRAFFIC, BUS2_TRAFFIC, EXT_TRAFFIC, EXT_WAKE_PATTERN, TEMP_CRIT, TEMP_OVER;
   logic RAILS_EN, IF_EN, WAKE_LOGIC_EN, MODEL_RUN, LED_GREEN, BEEP, TRIG_IRQ;
   int num_errors = 0, checked = 0, cycles = 0, n, m;
   int src[$] = '{SY_ECU, SY_BUS1, SY_BUS2, SY_EXT};
   logic [31:0] seed = 32'd62;
   supply_state_e exp_st;

   power_wakeup_sequencer #(.BOOT_CYC(20), .BEEP_CYC(5), .SLOT_CYC(4),
      .PIN_FILT_D(3), .TRIG_MIN_D(3)) u_dut (.CLK(CLK), .RST_B(RST_B), .CE(CE),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SUPPLY_PRESENT(SUPPLY_PRESENT),
      .SELECT_ON(SELECT_ON), .WAKE_PIN(WAKE_PIN), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B),
      .ETH_LINK(ETH_LINK), .ECU_TRAFFIC(ECU_TRAFFIC), .BUS1_TRAFFIC(BUS1_TRAFFIC),
      .BUS2_TRAFFIC(BUS2_TRAFFIC), .EXT_TRAFFIC(EXT_TRAFFIC),
      .EXT_WAKE_PATTERN(EXT_WAKE_PATTERN), .TEMP_CRIT(TEMP_CRIT), .TEMP_OVER(TEMP_OVER),
      .RAILS_EN(RAILS_EN), .IF_EN(IF_EN), .WAKE_LOGIC_EN(WAKE_LOGIC_EN),
      .MODEL_RUN(MODEL_RUN), .LED_GREEN(LED_GREEN), .BEEP(BEEP), .TRIG_IRQ(TRIG_IRQ),
      .STATE(STATE));
   wake_env u_env (.CLK(CLK), .SUPPLY_PRESENT(SUPPLY_PRESENT), .SELECT_ON(SELECT_ON),
      .WAKE_PIN(WAKE_PIN), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B), .ETH_LINK(ETH_LINK),
      .ECU_TRAFFIC(ECU_TRAFFIC), .BUS1_TRAFFIC(BUS1_TRAFFIC), .BUS2_TRAFFIC(BUS2_TRAFFIC),
      .EXT_TRAFFIC(EXT_TRAFFIC), .EXT_WAKE_PATTERN(EXT_WAKE_PATTERN),
      .TEMP_CRIT(TEMP_CRIT), .TEMP_OVER(TEMP_OVER));

   // Clock and hang guard
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         summarize();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // APB master: setup, access, hold until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      rd = PRDATA;
      err = PSLVERR;
      {PSEL, PENABLE} <= 2'b00;
      chk("pready", 1, PREADY);
   endtask
   task automatic wait_st(input supply_state_e e, input int lim);
      n = 0;
      while (STATE !== e && n < lim) begin
         @(negedge CLK);
         n++;
      end
      exp_st = e;
      chk("state", exp_st, STATE);
   endtask
   task automatic wait_hi(input string nm, ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(negedge CLK);
         n++;
      end
      chk(nm, 1, s);
   endtask
   task automatic count_hi(ref logic s, input int len);
      m = 0;
      repeat (len) begin
         @(negedge CLK);
         if (s === 1'b1) m++;
      end
   endtask
   task automatic summarize();
      if (num_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      RST_B = 1'b0;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      CE = 1'b1;
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      @(negedge CLK);
      wait_st(ST_OFF, 0);
      chk("wake_en", 0, WAKE_LOGIC_EN);
      apb(0, OFS_WAKE_CFG, 0);
      chk("wake_cfg", 32'h7F, rd);
      apb(0, 8'h18, 0);
      chk("slverr", 1, err);
      v = rnd() & 32'hFF;
      apb(1, OFS_ETH_IDLE, v);
      apb(0, OFS_ETH_IDLE, 0);
      chk("eth_idle", v, rd);
      apb(1, OFS_ETH_IDLE, 10);
      u_env.set(SY_SUPPLY, 1);
      wait_st(ST_ON, 10);
      chk("rails", 1, RAILS_EN);
      wait_hi("beep", BEEP, 40);
      wait_st(ST_STANDBY, 20);
      chk("if_en", 0, IF_EN);
      count_hi(LED_GREEN, 32);
      chk("flash", 12, m);
      u_env.pulse(SY_PIN, 2);
      repeat (10) @(negedge CLK);
      wait_st(ST_STANDBY, 0);
      u_env.set(SY_PIN, 1);
      wait_st(ST_ON, 12);
      chk("led", 1, LED_GREEN);
      u_env.set(SY_PIN, 0);
      wait_st(ST_STANDBY, 12);
      u_env.pulse(SY_ETH, 1);
      wait_st(ST_ON, 6);
      repeat (4) @(negedge CLK);
      wait_st(ST_ON, 0);
      wait_st(ST_STANDBY, 20);
      foreach (src[i]) begin
         u_env.set(src[i], 1);
         wait_st(ST_ON, 8);
         u_env.set(src[i], 0);
         wait_st(ST_STANDBY, 8);
      end
      // Clock enable low freezes the synchronizers and the state
      @(posedge CLK);
      CE <= 1'b0;
      u_env.set(SY_ECU, 1);
      repeat (8) @(negedge CLK);
      wait_st(ST_STANDBY, 0);
      @(posedge CLK);
      CE <= 1'b1;
      wait_st(ST_ON, 6);
      u_env.set(SY_ECU, 0);
      wait_st(ST_STANDBY, 8);
      // Critical temperature: short tones on the three-flash timebase
      u_env.set(SY_CRIT, 1);
      repeat (3) @(negedge CLK);
      count_hi(BEEP, 32);
      chk("crit_tone", 12, m);
      u_env.set(SY_CRIT, 0);
      u_env.pulse(SY_PATTERN, 2);
      wait_st(ST_ON, 6);
      wait_st(ST_STANDBY, 8);
      apb(1, OFS_WAKE_CFG, 32'h5F);
      u_env.set(SY_BUS1, 1);
      repeat (8) @(negedge CLK);
      wait_st(ST_STANDBY, 0);
      u_env.set(SY_BUS1, 0);
      apb(1, OFS_WAKE_CFG, 32'h7F);
      u_env.set(SY_SEL_ON, 1);
      wait_st(ST_ON, 6);
      u_env.set(SY_OVER, 1);
      wait_st(ST_STANDBY, 6);
      chk("model", 0, MODEL_RUN);
      count_hi(BEEP, 20);
      chk("beep_on", 20, m);
      u_env.set(SY_OVER, 0);
      wait_st(ST_ON, 6);
      u_env.set(SY_SEL_ON, 0);
      wait_st(ST_STANDBY, 6);
      u_env.pulse(SY_TRIG_A, 2);
      repeat (10) @(negedge CLK);
      chk("irq", 0, TRIG_IRQ);
      u_env.set(SY_TRIG_A, 1);
      wait_hi("irq", TRIG_IRQ, 10);
      apb(0, OFS_STATUS, 0);
      chk("button", 1, rd[3]);
      apb(0, OFS_TRIG_EVT, 0);
      chk("trig_evt", 3, rd);
      apb(1, OFS_TRIG_EVT, 3);
      repeat (2) @(negedge CLK);
      chk("irq", 0, TRIG_IRQ);
      // Release through the second input: change flag only, no press
      u_env.set(SY_TRIG_B, 1);
      repeat (6) @(negedge CLK);
      chk("irq", 0, TRIG_IRQ);
      apb(0, OFS_TRIG_EVT, 0);
      chk("trig_evt", 2, rd);
      u_env.set(SY_SUPPLY, 0);
      wait_st(ST_OFF, 6);
      chk("wake_en", 0, WAKE_LOGIC_EN);
      summarize();
   end
endmodule
`default_nettype wire
